// >>> rtl/rbm_pkg.sv
// Constants for the banked clock register map: register indexes, field positions and reset values.
// Assumes a 32-bit AXI4-Lite register bus where each 7-bit register index takes one aligned word.
package rbm_pkg;
    localparam int         ADDR_W        = 12;
    localparam logic [6:0] IDX_CTRL_A    = 7'h0A;
    localparam logic [6:0] IDX_CTRL_B    = 7'h0B;
    localparam logic [6:0] IDX_CTRL_C    = 7'h0C;
    localparam logic [6:0] IDX_CTRL_D    = 7'h0D;
    localparam logic [6:0] IDX_LOCK_LO   = 7'h38;
    localparam logic [6:0] IDX_BANK_LO   = 7'h40;
    localparam logic [6:0] IDX_WCTL1     = 7'h40;
    localparam logic [6:0] IDX_WCTL2     = 7'h41;
    localparam logic [6:0] IDX_WFLAGS    = 7'h42;
    localparam logic [6:0] IDX_WWEEKDAY  = 7'h43;
    localparam logic [6:0] IDX_WMDAY     = 7'h44;
    localparam logic [6:0] IDX_WMONTH    = 7'h45;
    localparam logic [6:0] IDX_WYEAR     = 7'h46;
    localparam logic [6:0] IDX_GUARD     = 7'h47;
    localparam logic [6:0] IDX_CENTURY   = 7'h48;
    localparam logic [6:0] IDX_UPTR      = 7'h50;
    localparam logic [6:0] IDX_UDATA     = 7'h53;
    localparam logic [6:0] UPPER_GUARDED = 7'h20;
    localparam int         BANK_LSB      = 4;
    localparam logic [1:0] BANK_0        = 2'h0;
    localparam logic [1:0] BANK_1        = 2'h1;
    localparam logic [1:0] BANK_2        = 2'h2;
    localparam int         CTRL_A_RO_BIT = 7;
    localparam int         CTRL_B_RO_BIT = 3;
    localparam int         WCTL1_PFAIL   = 7;
    localparam logic [7:0] WCTL1_WO_MASK = 8'h68;
    localparam logic [6:0] WFLAGS_RESET  = 7'h41;
    localparam logic [6:0] WFLAGS_RC     = 7'h3F;
    localparam logic [7:0] GUARD_MASK    = 8'hF8;
    localparam int         G_UDATA       = 3;
    localparam int         G_RD_LOW32    = 4;
    localparam int         G_WR_LOW32    = 5;
    localparam int         G_RAM_WR      = 6;
    localparam int         G_LOCK_HI8    = 7;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [7:0] BYTE_BLOCKED  = 8'hFF;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// >>> rtl/rbm_register_map.sv
// Banked register space of a battery-backed clock with a wake-up extension, as an AXI4-Lite slave.
// Assumes timekeeping and event detection sit outside and feed status bits in; aresetn is the
// first power-up reset, master_reset_pin the hardware master reset.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module rbm_register_map
    import rbm_pkg::*;
(
    input  wire logic              aclk,             // 40 MHz clock
    input  wire logic              aresetn,          // First power-up reset, synchronous
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // Write address
    input  wire logic              s_axi_awvalid,    // Write address valid
    output logic                   s_axi_awready,    // Write address ready
    input  wire logic [31:0]       s_axi_wdata,      // Write data
    input  wire logic [3:0]        s_axi_wstrb,      // Write byte enables
    input  wire logic              s_axi_wvalid,     // Write data valid
    output logic                   s_axi_wready,     // Write data ready
    output logic [1:0]             s_axi_bresp,      // Write response
    output logic                   s_axi_bvalid,     // Write response valid
    input  wire logic              s_axi_bready,     // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,     // Read address
    input  wire logic              s_axi_arvalid,    // Read address valid
    output logic                   s_axi_arready,    // Read address ready
    output logic [31:0]            s_axi_rdata,      // Read data
    output logic [1:0]             s_axi_rresp,      // Read response
    output logic                   s_axi_rvalid,     // Read data valid
    input  wire logic              s_axi_rready,     // Read data ready
    input  wire logic              master_reset_pin, // Hardware master reset, active high
    input  wire logic              update_busy,      // Control A bit 7 from the timekeeper
    input  wire logic [7:0]        clock_status_c,   // Control C contents from the timekeeper
    input  wire logic [7:0]        clock_status_d,   // Control D contents from the timekeeper
    input  wire logic [5:0]        wake_event_set,   // Wake event pulses for flag bits 5-0
    input  wire logic              ring_level,       // Live level of the selected ring pin
    input  wire logic              power_fail_set,   // Pulse: switched to battery supply
    output logic [7:0]             ctrl_a_o,         // Control A as stored
    output logic [7:0]             ctrl_b_o,         // Control B as stored
    output logic [7:0]             wake_control_one, // Wake control 1
    output logic [7:0]             wake_control_two  // Wake control 2
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] low_mem  [0:63];
    logic [7:0] bank0_mem[0:63];
    logic [7:0] upper_mem[0:127];

    logic [7:0] ctrl_a_q, ctrl_b_q, wctl1_q, wctl2_q, century_q, guard_q;
    logic [7:0] wweekday_q, wmday_q, wmonth_q, wyear_q, wcentury_q;
    logic [6:0] wflags_q, uptr_q;
    logic       bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_byte;

    function automatic logic in_map(input logic [ADDR_W-1:0] a);
        in_map = (a[ADDR_W-1:9] == '0);
    endfunction

    function automatic logic guarded_low(input logic [6:0] idx, input logic [7:0] g);
        guarded_low = g[G_LOCK_HI8] && (idx >= IDX_LOCK_LO) && (idx < IDX_BANK_LO);
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    logic       wr_fire, rd_fire, wr_en, rd_ok;
    logic [6:0] widx, ridx;
    logic [7:0] wd;
    logic [1:0] bank;
    logic       hi_w;
    logic       upper_blk_w;

    // Address and data are taken together; this keeps a single write in flight.
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !rvalid_q;
    assign wr_fire       = s_axi_awready;
    assign rd_fire       = s_axi_arvalid && !rvalid_q;
    assign widx          = s_axi_awaddr[8:2];
    assign ridx          = s_axi_araddr[8:2];
    assign wd            = s_axi_wdata[7:0];
    assign wr_en         = wr_fire && in_map(s_axi_awaddr) && s_axi_wstrb[0];
    assign rd_ok         = in_map(s_axi_araddr);
    assign bank          = ctrl_a_q[BANK_LSB +: 2];
    assign hi_w          = wr_en && (widx >= IDX_BANK_LO);
    assign upper_blk_w   = guard_q[G_UDATA] || guard_q[G_RAM_WR]
                           || (guard_q[G_WR_LOW32] && (uptr_q < UPPER_GUARDED));

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = {24'h000000, rdata_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= in_map(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= BYTE_ZERO;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= rd_ok ? rd_byte : BYTE_ZERO;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    // Reserved holes, bank 3 included, read as zero rather than as stale storage.
    always_comb begin
        rd_byte = BYTE_ZERO;
        if (ridx < IDX_BANK_LO) begin
            if (guarded_low(ridx, guard_q)) begin
                rd_byte = BYTE_BLOCKED;
            end else if (ridx == IDX_CTRL_A) begin
                rd_byte = {update_busy, ctrl_a_q[CTRL_A_RO_BIT-1:0]};
            end else if (ridx == IDX_CTRL_B) begin
                rd_byte = ctrl_b_q;
            end else if (ridx == IDX_CTRL_C) begin
                rd_byte = clock_status_c;
            end else if (ridx == IDX_CTRL_D) begin
                rd_byte = clock_status_d;
            end else begin
                rd_byte = low_mem[ridx[5:0]];
            end
        end else if (bank == BANK_0) begin
            rd_byte = bank0_mem[ridx[5:0]];
        end else if (bank == BANK_1) begin
            if (ridx == IDX_CENTURY) begin
                rd_byte = century_q;
            end else if (ridx == IDX_UPTR) begin
                rd_byte = {1'b0, uptr_q};
            end else if (ridx == IDX_UDATA) begin
                if (guard_q[G_UDATA] || (guard_q[G_RD_LOW32] && (uptr_q < UPPER_GUARDED))) begin
                    rd_byte = BYTE_BLOCKED;
                end else begin
                    rd_byte = upper_mem[uptr_q];
                end
            end
        end else if (bank == BANK_2) begin
            unique case (ridx)
                IDX_WCTL1:    rd_byte = wctl1_q & ~WCTL1_WO_MASK;
                IDX_WCTL2:    rd_byte = wctl2_q;
                IDX_WFLAGS:   rd_byte = {ring_level, wflags_q};
                IDX_WWEEKDAY: rd_byte = wweekday_q;
                IDX_WMDAY:    rd_byte = wmday_q;
                IDX_WMONTH:   rd_byte = wmonth_q;
                IDX_WYEAR:    rd_byte = wyear_q;
                IDX_GUARD:    rd_byte = guard_q;
                IDX_CENTURY:  rd_byte = wcentury_q;
                default:      rd_byte = BYTE_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Shared lower region
    // ------------------------------------------------------------------
    // Clock fields are plain bytes here: hour and weekday codes are kept exactly as written.
    always_ff @(posedge aclk) begin
        if (wr_en && (widx < IDX_BANK_LO) && !guarded_low(widx, guard_q)
            && (widx != IDX_CTRL_A) && (widx != IDX_CTRL_B)
            && (widx != IDX_CTRL_C) && (widx != IDX_CTRL_D)) begin
            low_mem[widx[5:0]] <= wd;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_q <= BYTE_ZERO;
            ctrl_b_q <= BYTE_ZERO;
        end else if (wr_en && !guarded_low(widx, guard_q)) begin
            if (widx == IDX_CTRL_A) begin
                ctrl_a_q <= {ctrl_a_q[CTRL_A_RO_BIT], wd[CTRL_A_RO_BIT-1:0]};
            end
            if (widx == IDX_CTRL_B) begin
                ctrl_b_q <= {wd[7:CTRL_B_RO_BIT+1], ctrl_b_q[CTRL_B_RO_BIT], wd[CTRL_B_RO_BIT-1:0]};
            end
        end
    end

    assign ctrl_a_o = ctrl_a_q;
    assign ctrl_b_o = ctrl_b_q;

    // ------------------------------------------------------------------
    // Bank 0 RAM and bank 1 upper RAM
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (hi_w && (bank == BANK_0) && !guard_q[G_RAM_WR]) begin
            bank0_mem[widx[5:0]] <= wd;
        end
    end

    always_ff @(posedge aclk) begin
        if (hi_w && (bank == BANK_1) && (widx == IDX_UDATA) && !upper_blk_w) begin
            upper_mem[uptr_q] <= wd;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            century_q <= BYTE_ZERO;
            uptr_q    <= '0;
        end else if (hi_w && (bank == BANK_1)) begin
            if (widx == IDX_CENTURY) begin
                century_q <= wd;
            end
            if (widx == IDX_UPTR) begin
                uptr_q <= wd[6:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Bank 2 wake-up registers
    // ------------------------------------------------------------------
    // Only the power-up reset reaches these, except guard_q, which master_reset_pin also clears; there is no system reset input by design.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wctl1_q <= BYTE_ZERO;
            wctl2_q <= BYTE_ZERO;
        end else begin
            if (hi_w && (bank == BANK_2) && (widx == IDX_WCTL1)) begin
                wctl1_q[WCTL1_PFAIL-1:0] <= wd[WCTL1_PFAIL-1:0];
            end
            if (hi_w && (bank == BANK_2) && (widx == IDX_WCTL2)) begin
                wctl2_q <= wd;
            end
            // Power failure flag: a set in the same cycle beats a write-one clear.
            if (power_fail_set) begin
                wctl1_q[WCTL1_PFAIL] <= 1'b1;
            end else if (hi_w && (bank == BANK_2) && (widx == IDX_WCTL1) && wd[WCTL1_PFAIL]) begin
                wctl1_q[WCTL1_PFAIL] <= 1'b0;
            end
        end
    end

    assign wake_control_one = wctl1_q;
    assign wake_control_two = wctl2_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wflags_q <= WFLAGS_RESET;
        end else begin
            // A new event in the reading cycle survives the clear.
            if (rd_fire && rd_ok && (ridx == IDX_WFLAGS) && (bank == BANK_2)) begin
                wflags_q <= (wflags_q & ~WFLAGS_RC) | {1'b0, wake_event_set};
            end else begin
                wflags_q <= wflags_q | {1'b0, wake_event_set};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wweekday_q <= BYTE_ZERO;
            wmday_q    <= BYTE_ZERO;
            wmonth_q   <= BYTE_ZERO;
            wyear_q    <= BYTE_ZERO;
            wcentury_q <= BYTE_ZERO;
        end else if (hi_w && (bank == BANK_2)) begin
            unique case (widx)
                IDX_WWEEKDAY: wweekday_q <= wd;
                IDX_WMDAY:    wmday_q    <= wd;
                IDX_WMONTH:   wmonth_q   <= wd;
                IDX_WYEAR:    wyear_q    <= wd;
                IDX_CENTURY:  wcentury_q <= wd;
                default:      wyear_q    <= wyear_q;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || master_reset_pin) begin
            guard_q <= BYTE_ZERO;
        end else if (hi_w && (bank == BANK_2) && (widx == IDX_GUARD)) begin
            guard_q <= guard_q | (wd & GUARD_MASK);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Each check looks one cycle after its triggering condition, when the register has settled.
    AST_FLAGS_READ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_ok && ridx == IDX_WFLAGS && bank == BANK_2 && wake_event_set == '0
        |=> (wflags_q & WFLAGS_RC) == '0)
        else $error("wake flags not cleared by read");
    AST_GUARD_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        !master_reset_pin |=> (guard_q & $past(guard_q)) == $past(guard_q))
        else $error("guard bit cleared without master reset");
    AST_MR_CLEARS_GUARD: assert property (@(posedge aclk) disable iff (!aresetn)
        master_reset_pin |=> guard_q == BYTE_ZERO)
        else $error("guard not cleared by master reset");
    AST_WCTL2_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !(hi_w && bank == BANK_2 && widx == IDX_WCTL2) |=> $stable(wctl2_q))
        else $error("wake control two changed without a write");
    AST_B1_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_ok && bank == BANK_1 && ridx >= IDX_BANK_LO && ridx < IDX_CENTURY
        |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
        else $error("bank 1 reserved index read nonzero");
    AST_B2_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_ok && bank == BANK_2 && ridx > IDX_CENTURY
        |=> s_axi_rdata == 32'h00000000)
        else $error("bank 2 reserved index read nonzero");
    AST_CTRL_C_LIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_ok && ridx == IDX_CTRL_C |=> s_axi_rdata[7:0] == $past(clock_status_c))
        else $error("control C read wrong");
    AST_CTRL_B_BIT3: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && widx == IDX_CTRL_B |=> $stable(ctrl_b_q[CTRL_B_RO_BIT]))
        else $error("control B bit 3 written");
    AST_CENTURY_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        hi_w && bank == BANK_1 && widx == IDX_CENTURY |=> century_q == $past(s_axi_wdata[7:0]))
        else $error("century write lost");
    AST_POINTER_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        hi_w && bank == BANK_1 && widx == IDX_UPTR |=> uptr_q == $past(s_axi_wdata[6:0]))
        else $error("upper pointer write lost");
    AST_CTRL_A_BIT7: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_en && widx == IDX_CTRL_A |=> $stable(ctrl_a_q[CTRL_A_RO_BIT]))
        else $error("control A bit 7 written");
    AST_WYEAR_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        hi_w && bank == BANK_2 && widx == IDX_WYEAR |=> wyear_q == $past(wd))
        else $error("wake year write lost");
    AST_WCTL2_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        hi_w && bank == BANK_2 && widx == IDX_WCTL2 |=> wctl2_q == $past(wd))
        else $error("wake control two write lost");
    AST_FLAGS_READ_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
        !(rd_fire && ridx == IDX_WFLAGS) && wake_event_set == '0 |=> $stable(wflags_q))
        else $error("wake flags changed without event or read");
    AST_B0_RAM_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_ok && bank == BANK_0 && ridx >= IDX_BANK_LO
        |=> s_axi_rdata[7:0] == $past(bank0_mem[ridx[5:0]]))
        else $error("bank 0 RAM read wrong");

endmodule

`default_nettype wire

// >>> testbench/rbm_host_model.sv
// Host-side AXI4-Lite master model: issues one read or one write at a time on request.
// Assumes the slave answers in its own time; the bench watchdog bounds every wait.
`timescale 1ns/1ps
`default_nettype none
module rbm_host_model
    import rbm_pkg::*;
(
    input  wire logic              aclk,          // Bus clock
    output logic [ADDR_W-1:0]      s_axi_awaddr,  // Write address
    output logic                   s_axi_awvalid, // Write address valid
    input  wire logic              s_axi_awready, // Write address ready
    output logic [31:0]            s_axi_wdata,   // Write data
    output logic [3:0]             s_axi_wstrb,   // Write byte enables
    output logic                   s_axi_wvalid,  // Write data valid
    input  wire logic              s_axi_wready,  // Write data ready
    input  wire logic [1:0]        s_axi_bresp,   // Write response
    input  wire logic              s_axi_bvalid,  // Write response valid
    output logic                   s_axi_bready,  // Write response ready
    output logic [ADDR_W-1:0]      s_axi_araddr,  // Read address
    output logic                   s_axi_arvalid, // Read address valid
    input  wire logic              s_axi_arready, // Read address ready
    input  wire logic [31:0]       s_axi_rdata,   // Read data
    input  wire logic [1:0]        s_axi_rresp,   // Read response
    input  wire logic              s_axi_rvalid,  // Read data valid
    output logic                   s_axi_rready   // Read data ready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
    end

    // Each task starts on a fresh edge so back-to-back calls never assign a signal twice in one step.
    task automatic write(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw_on, w_on;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        aw_on = 1'b1;
        w_on  = 1'b1;
        while (aw_on || w_on) begin
            @(posedge aclk);
            if (aw_on && s_axi_awready) begin
                aw_on = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_on && s_axi_wready) begin
                w_on = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready  <= 1'b0;
    endtask

    task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready  <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/test_rbm_register_map.sv
// Self-checking bench for the banked register map, driving it through the host model.
// Assumes byte address = 4 * index and bank select in control A bits 5:4.
`timescale 1ns/1ps
`default_nettype none
module test_rbm_register_map;
    import rbm_pkg::*;
    logic aclk, aresetn, master_reset_pin, update_busy, ring_level, power_fail_set;
    logic [7:0] clock_status_c, clock_status_d, ca, cb, wc1, wc2, d;
    logic [5:0] wake_event_set, e;
    logic [6:0] ix;
    logic [1:0] rs;
    logic [31:0] x;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] wk [6] = '{IDX_WWEEKDAY, IDX_WMDAY, IDX_WMONTH, IDX_WYEAR, IDX_CENTURY, IDX_WCTL2};
    int error_cnt, comparisons;

    rbm_register_map rbm_register_map_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .master_reset_pin, .update_busy, .clock_status_c, .clock_status_d, .wake_event_set,
        .ring_level, .power_fail_set, .ctrl_a_o(ca), .ctrl_b_o(cb), .wake_control_one(wc1), .wake_control_two(wc2));
    rbm_host_model rbm_host_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    function automatic logic [7:0] flags_exp(input logic [5:0] f);
        return {ring_level, 1'b1, f};
    endfunction

    task automatic wr(input logic [6:0] i, input logic [7:0] v);
        logic [1:0] r;
        rbm_host_model_i.write({3'h0, i, 2'h0}, v, r);
    endtask

    task automatic chk8(input string n, input logic [7:0] ex, input logic [7:0] g);
        comparisons++;
        if (g !== ex) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, ex, g);
        end
    endtask

    task automatic chk2(input string n, input logic [1:0] ex, input logic [1:0] g);
        comparisons++;
        if (g !== ex) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, ex, g);
        end
    endtask

    task automatic rdchk(input string n, input logic [6:0] i, input logic [7:0] ex);
        rbm_host_model_i.read({3'h0, i, 2'h0}, x, rs);
        chk8(n, ex, x[7:0]);
    endtask

    task automatic bank(input logic [1:0] b);
        wr(IDX_CTRL_A, {2'b00, b, 4'h0});
    endtask

    task automatic give_verdict();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // A full run needs well under two thousand cycles; the margin absorbs slow answers.
    initial begin
        repeat (8000) @(posedge aclk);
        error_cnt++;
        give_verdict();
    end

    initial begin
        {error_cnt, comparisons} = '0;
        {aresetn, master_reset_pin, update_busy, ring_level, power_fail_set} = '0;
        {clock_status_c, clock_status_d, wake_event_set} = '0;
        void'($urandom(32'h0a92d409));
        repeat (12) @(posedge aclk);
        aresetn     <= 1'b1;
        update_busy <= 1'b1;
        bank(BANK_2);
        rdchk("wctl1", IDX_WCTL1, 8'h00);
        rdchk("wctl2", IDX_WCTL2, 8'h00);
        rdchk("wflags", IDX_WFLAGS, flags_exp(6'h01));
        rdchk("guard", IDX_GUARD, 8'h00);
        bank(BANK_1);
        rdchk("century", IDX_CENTURY, 8'h00);
        rdchk("ctrl_a", IDX_CTRL_A, {2'b10, BANK_1, 4'h0});
        for (int k = 0; k < 9; k++) begin
            ix = 7'h0E + 7'($urandom_range(41));
            d  = 8'($urandom);
            bank(2'(k % 3));
            wr(ix, d);
            bank(2'((k + 1) % 3));
            rdchk("common", ix, d);
        end
        ix = 7'h40 + 7'($urandom_range(63));
        d  = 8'($urandom);
        wr(ix, d);
        rdchk("bank0_ram", ix, d);
        bank(BANK_1);
        ix = 7'h40 + 7'($urandom_range(7));
        wr(ix, 8'hA5);
        rdchk("reserved_low", ix, 8'h00);
        rdchk("reserved_high", 7'h54 + 7'($urandom_range(43)), 8'h00);
        wr(IDX_CTRL_B, 8'hFF);
        rdchk("ctrl_b", IDX_CTRL_B, 8'hF7);
        chk8("ctrl_b_o", 8'hF7, cb);
        chk8("ctrl_a_o", {2'b00, BANK_1, 4'h0}, ca);
        d = 8'($urandom);
        clock_status_c <= d;
        clock_status_d <= ~d;
        wr(IDX_CTRL_C, 8'h00);
        rdchk("ctrl_c", IDX_CTRL_C, d);
        rdchk("ctrl_d", IDX_CTRL_D, ~d);
        wr(7'h04, 8'h92);
        rdchk("hours_pm", 7'h04, 8'h92);
        wr(7'h06, 8'h01);
        rdchk("weekday", 7'h06, 8'h01);
        for (int k = 0; k < 4; k++) begin
            ix = 7'($urandom);
            d  = 8'($urandom);
            wr(IDX_UPTR, {1'b0, ix});
            wr(IDX_UDATA, d);
            rdchk("upper_ptr", IDX_UPTR, {1'b0, ix});
            rdchk("upper_data", IDX_UDATA, d);
        end
        d = 8'($urandom_range(99));
        wr(IDX_CENTURY, d);
        rdchk("century", IDX_CENTURY, d);
        bank(BANK_2);
        for (int k = 0; k < 6; k++) begin
            d = 8'($urandom);
            wr(wk[k], d);
            rdchk("wake_reg", wk[k], d);
        end
        chk8("wctl2_o", d, wc2);
        ring_level <= 1'b1;
        d = 8'($urandom) & 8'h17;
        wr(IDX_WCTL1, d);
        rdchk("wctl1", IDX_WCTL1, d);
        power_fail_set <= 1'b1;
        @(posedge aclk);
        power_fail_set <= 1'b0;
        rdchk("wctl1", IDX_WCTL1, d | 8'h80);
        chk8("wctl1_o", d | 8'h80, wc1);
        rdchk("wflags", IDX_WFLAGS, flags_exp(6'h00));
        e = 6'($urandom_range(63, 1));
        @(posedge aclk);
        wake_event_set <= e;
        @(posedge aclk);
        wake_event_set <= 6'h00;
        rdchk("wflags", IDX_WFLAGS, flags_exp(e));
        rdchk("wflags", IDX_WFLAGS, flags_exp(6'h00));
        rdchk("reserved2", 7'h49 + 7'($urandom_range(54)), 8'h00);
        wr(IDX_GUARD, 8'h80);
        wr(IDX_GUARD, 8'h00);
        rdchk("guard", IDX_GUARD, 8'h80);
        rdchk("locked_ram", 7'h38, 8'hFF);
        @(posedge aclk);
        master_reset_pin <= 1'b1;
        @(posedge aclk);
        master_reset_pin <= 1'b0;
        rdchk("guard", IDX_GUARD, 8'h00);
        rbm_host_model_i.write(12'hE00, 8'h00, rs);
        chk2("unmapped_wr", RESP_SLVERR, rs);
        rbm_host_model_i.read(12'hE00, x, rs);
        chk2("unmapped_rd", RESP_SLVERR, rs);
        give_verdict();
    end
endmodule
`default_nettype wire
